// *** include/cdb_pkg.sv ***
// Package for the counter/delay block with snapshot read-back.
// Assumes a single 200 MHz system clock; all slower rates are enables.
package cdb_pkg;
   localparam int CDB_CLK_MHZ = 200;
   localparam int CDB_CNT_W = 8;
   localparam logic [7:0] CDB_CNT_RST = 8'h00;
   localparam logic [7:0] CDB_SNAP_RST = 8'h00;
   // Glitch filter: pulses up to this width are removed
   localparam int CDB_FLT_NS = 10;
   localparam int CDB_FLT_PERIOD_NS = 60;
   localparam int CDB_FLT_CYC = (CDB_FLT_NS * CDB_CLK_MHZ + 999) / 1000 + 1;
   localparam int CDB_SYNC_STAGES = 2;
   // Clock source selection
   typedef enum logic [1:0] {
      CDB_SRC_OSC = 2'b00,
      CDB_SRC_MATRIX = 2'b01,
      CDB_SRC_OFF = 2'b10
   } cdb_src_e;
endpackage : cdb_pkg

// *** rtl/cdb_counter_delay_block.sv ***
// Counter/delay block: 8-bit down counter with snapshot read-back
// and a glitch filter ahead of a delay stage.
// Assumes all inputs are synchronous to clk; the counting clock arrives
// as a level input sampled here and is turned into a count enable.
// Notes on behaviour
// - The 8-bit count is readable by the serial host.
// - A host read request latches the running count into a read-back register.
// - Snapshots never disturb counting.
// - Halting the clock lengthens the effective period by the read time.
// - Matrix source with nothing routed holds the counter clock low.
// - Counter reset passes two clk flip-flops that advance only on counting-clock edges.
// - Reset coinciding with a count edge still reloads data correctly.
// - Filter suppresses short glitches and sits ahead of the delay stage.
// - Filter blocks 10 ns pulses repeating every 60 ns.
`timescale 1ns/1ps
module cdb_counter_delay_block
   import cdb_pkg::*;
#(
   parameter int CNT_W = CDB_CNT_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic osc_clk,
   input wire logic osc_on,
   input wire logic matrix_clk,
   input wire logic matrix_routed,
   input wire logic [1:0] src_sel,
   input wire logic [CNT_W-1:0] reload_data,
   input wire logic cnt_rst,
   input wire logic read_req,
   input wire logic flt_in,
   output logic [CNT_W-1:0] count_out,
   output logic [CNT_W-1:0] snap_out,
   output logic snap_valid,
   output logic cnt_pulse,
   output logic delay_out
);
   logic rst_s1_r, rst_s2_r;
   logic rst_sync_n;
   logic src_clk_r, src_prev_r;
   logic cnt_edge;
   logic rsync1_r, rsync2_r;
   logic rd_pend_r;
   logic [CNT_W-1:0] cnt_r;
   logic flt_out;
   logic flt_q_r;

   // Release reset through two flip-flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   assign rst_sync_n = rst_s2_r;

   // Select counting clock; unrouted matrix input ties low
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         src_clk_r <= 1'b0;
         src_prev_r <= 1'b0;
      end else begin
         src_prev_r <= src_clk_r;
         unique case (cdb_src_e'(src_sel))
            CDB_SRC_OSC: src_clk_r <= osc_clk & osc_on;
            CDB_SRC_MATRIX: src_clk_r <= matrix_clk & matrix_routed;
            default: src_clk_r <= 1'b0;
         endcase
      end
   end
   // One-cycle count enable; a gated clock that restarts high counts once
   assign cnt_edge = src_clk_r & ~src_prev_r;

   // Counter reset synchronised on counting edges, two stages
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rsync1_r <= 1'b0;
         rsync2_r <= 1'b0;
      end else if (cnt_edge) begin
         rsync1_r <= cnt_rst;
         rsync2_r <= rsync1_r;
      end
   end

   // Down counter; reset and reload are whole-word, never partial
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cnt_r <= CDB_CNT_RST;
         cnt_pulse <= 1'b0;
      end else begin
         cnt_pulse <= 1'b0;
         if (cnt_edge) begin
            if (rsync2_r) begin
               cnt_r <= reload_data;
            end else if (cnt_r == '0) begin
               cnt_r <= reload_data;
               cnt_pulse <= 1'b1;
            end else begin
               cnt_r <= cnt_r - 1'b1;
            end
         end
      end
   end

   // Live count, one clk behind the counter
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         count_out <= CDB_CNT_RST;
      end else begin
         count_out <= cnt_r;
      end
   end

   // Snapshot taken away from count edges so the word is coherent
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rd_pend_r <= 1'b0;
         snap_out <= CDB_SNAP_RST;
         snap_valid <= 1'b0;
      end else begin
         snap_valid <= 1'b0;
         if ((read_req || rd_pend_r) && !cnt_edge) begin
            snap_out <= cnt_r;
            snap_valid <= 1'b1;
            rd_pend_r <= 1'b0;
         end else if (read_req) begin
            rd_pend_r <= 1'b1;
         end
      end
   end

   // Filter ahead of the delay stage
   cdb_glitch_filter #(.STABLE_CYC(CDB_FLT_CYC)) u_flt (
      .clk(clk),
      .rst_n(rst_sync_n),
      .din(flt_in),
      .dout(flt_out)
   );

   // Delay stage: one count period behind, only filtered input reaches it
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         flt_q_r <= 1'b0;
         delay_out <= 1'b0;
      end else begin
         flt_q_r <= flt_out;
         if (cnt_pulse) begin
            delay_out <= flt_q_r;
         end
      end
   end

   snap_match_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
      snap_valid |-> snap_out == $past(cnt_r))
      else $error("snapshot does not match count");
   snap_within_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
      read_req |-> ##[1:2] snap_valid)
      else $error("snapshot not taken in time");
   count_hold_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
      !$past(cnt_edge) |-> $stable(cnt_r))
      else $error("count moved without an edge");
   unrouted_low_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
      src_sel == CDB_SRC_MATRIX && !matrix_routed |=> !src_clk_r)
      else $error("unrouted source not held low");
   rst_two_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
      $rose(rsync2_r) |-> $past(rsync1_r))
      else $error("reset skipped a stage");
   reload_ok_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
      cnt_edge && rsync2_r |=> cnt_r == $past(reload_data))
      else $error("reset reload wrong");
   count_out_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
      ##1 count_out == $past(cnt_r))
      else $error("count output stale");
   dec_step_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
      cnt_edge && !rsync2_r && cnt_r != '0 |=> cnt_r == $past(cnt_r) - 1'b1)
      else $error("count step wrong");


   // Snapshot path: word holds between snapshots, deferral lasts one cycle
   snap_hold_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
      !snap_valid |-> $stable(snap_out))
      else $error("snapshot changed without a read");
   pend_once_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
      rd_pend_r |=> !rd_pend_r)
      else $error("deferred read held too long");
   edge_single_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
      cnt_edge |=> !cnt_edge)
      else $error("count enable longer than one cycle");

   // Counting, source gating and reset stages
   wrap_load_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
      cnt_edge && !rsync2_r && cnt_r == '0 |=> cnt_pulse && cnt_r == $past(reload_data))
      else $error("wrap did not reload");
   pulse_one_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
      cnt_pulse |=> !cnt_pulse)
      else $error("wrap pulse too long");
   osc_gate_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
      src_sel == CDB_SRC_OSC && !osc_on |=> !src_clk_r)
      else $error("halted oscillator still counts");
   off_low_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
      src_sel != CDB_SRC_OSC && src_sel != CDB_SRC_MATRIX |=> !src_clk_r)
      else $error("source off not held low");
   rst_hold_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
      !$past(cnt_edge) |-> $stable(rsync2_r))
      else $error("reset stage moved without an edge");

   // Delay stage only moves on a wrap, from the filtered input
   delay_hold_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
      !$past(cnt_pulse) |-> $stable(delay_out))
      else $error("delay output moved without a wrap");
   dly_src_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
      cnt_pulse |=> delay_out == $past(flt_q_r))
      else $error("delay output not from filter");

   // Main scenarios
   read_cov: cover property (@(posedge clk) snap_valid);
   wrap_cov: cover property (@(posedge clk) cnt_pulse);
   coinc_cov: cover property (@(posedge clk) read_req && cnt_edge);
   dly_cov: cover property (@(posedge clk) $rose(delay_out));
   defer_cov: cover property (@(posedge clk) rd_pend_r);
endmodule : cdb_counter_delay_block

// *** rtl/cdb_glitch_filter.sv ***
// Glitch filter placed ahead of a delay cell.
// Assumes input synchronous to clk; output follows input only after it
// has been stable for more than the suppress width.
`timescale 1ns/1ps
module cdb_glitch_filter
   import cdb_pkg::*;
#(
   parameter int STABLE_CYC = CDB_FLT_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic din,
   output logic dout
);
   logic [7:0] run_r;
   logic last_r;

   // Count how long the input has held its level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_r <= 8'h00;
         last_r <= 1'b0;
      end else begin
         last_r <= din;
         if (din != last_r) begin
            run_r <= 8'h00;
         end else if (run_r != 8'hff) begin
            run_r <= run_r + 8'h01;
         end
      end
   end

   // Short pulses never reach the count, so they never pass
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dout <= 1'b0;
      end else if (din == last_r && run_r >= 8'(STABLE_CYC - 1)) begin
         dout <= din;
      end
   end

   flt_block_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(dout) |-> $past(din, 3) && $past(din, 2) && $past(din, 1))
      else $error("filter passed a short pulse");
endmodule : cdb_glitch_filter

// *** tb/cdb_host_model.sv ***
// Host model: halts the counting clock, requests a snapshot, collects it.
// Assumes read_req is taken at a clk edge and answered by snap_valid.
`timescale 1ns/1ps
module cdb_host_model
   import cdb_pkg::*;
(
   input wire logic clk,
   input wire logic go,
   input wire logic halt,
   input wire logic snap_valid,
   input wire logic [7:0] snap_out,
   output logic osc_on = 1'b1,
   output logic read_req = 1'b0,
   output logic [7:0] data = 8'h00,
   output logic ok = 1'b0,
   output logic done = 1'b0
);
   // Read sequence; a halt adds the read time to the period
   always @(posedge clk) begin
      if (go) begin
         if (halt) osc_on <= 1'b0;
         repeat (3) @(posedge clk);
         read_req <= 1'b1;
         @(posedge clk);
         read_req <= 1'b0;
         ok = 1'b0;
         // Bounded wait, answer may be deferred a cycle; sampled at the edge
         for (int i = 0; i < 8 && !ok; i++) begin
            @(posedge clk);
            ok = (snap_valid === 1'b1);
            if (ok) data <= snap_out;
         end
         osc_on <= 1'b1;
         done <= 1'b1;
         @(posedge clk);
         done <= 1'b0;
      end
   end
endmodule : cdb_host_model

// *** tb/test_counter_delay_with_readback.sv ***
// Testbench for the counter/delay block with snapshot read-back.
// Assumes cdb_host_model; one counting tick lasts eight clk cycles.
`timescale 1ns/1ps
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin error_cnt++; $display("CHECK FAILED %0t %s", $time, m); end end
module test_counter_delay_with_readback;
   import cdb_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, ck = 1'b0, routed = 1'b1, cnt_rst = 1'b0, flt_in = 1'b0, go = 1'b0, hh = 1'b1;
   logic [1:0] src_sel = CDB_SRC_OSC;
   logic [7:0] reload = 8'h05;
   logic [7:0] count_out, snap_out, data;
   logic osc_on, read_req, snap_valid, cnt_pulse, delay_out, ok, done;
   int error_cnt = 0, num_checks = 0, pulses = 0;
   initial forever #2.5 clk = ~clk;
   // Wrap pulses, counted for period checks
   always @(posedge clk) if (cnt_pulse === 1'b1) pulses <= pulses + 1;
   cdb_counter_delay_block dut_u (.clk(clk), .rst_n(rst_n), .osc_clk(ck), .osc_on(osc_on), .matrix_clk(ck),
      .matrix_routed(routed), .src_sel(src_sel), .reload_data(reload), .cnt_rst(cnt_rst), .read_req(read_req),
      .flt_in(flt_in), .count_out(count_out), .snap_out(snap_out), .snap_valid(snap_valid),
      .cnt_pulse(cnt_pulse), .delay_out(delay_out));
   cdb_host_model host_u (.clk(clk), .go(go), .halt(hh), .snap_valid(snap_valid), .snap_out(snap_out),
      .osc_on(osc_on), .read_req(read_req), .data(data), .ok(ok), .done(done));
   task automatic results();
      if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : results
   // Slow counting clock, well above the two-cycle edge detect
   task automatic tick(input int n);
      repeat (n) begin
         ck <= 1'b1;
         repeat (4) @(posedge clk);
         ck <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask : tick
   task automatic rd(input logic h);
      go <= 1'b1;
      hh <= h;
      @(posedge clk);
      go <= 1'b0;
      for (int i = 0; i < 40 && done !== 1'b1; i++) @(posedge clk);
      if (done !== 1'b1) begin
         error_cnt++;
         results();
      end
      `CHK(ok, 1'b1, "no snapshot")
   endtask : rd
   // First edge from zero wraps, then one wrap per six edges
   task automatic t_count();
      int p0;
      p0 = pulses;
      tick(18);
      `CHK(pulses - p0, 3, "wraps")
      `CHK(count_out, 8'h00, "count")
   endtask : t_count
   // Halted read gives the live count; a running read leaves counting intact
   task automatic t_read();
      int p0;
      tick(2);
      rd(1'b1);
      `CHK(data, 8'h04, "snapshot")
      p0 = pulses;
      fork
         rd(1'b0);
         tick(6);
      join
      `CHK(pulses - p0, 1, "wraps in read")
      `CHK(count_out, 8'h04, "count in read")
      // Request lands on a count edge: deferred, post-edge value returned
      fork
         rd(1'b0);
         begin
            repeat (3) @(posedge clk);
            tick(6);
         end
      join
      `CHK(data, 8'h03, "coincident snapshot")
   endtask : t_read
   // Unrouted matrix or source off holds the clock low
   task automatic t_src();
      src_sel <= CDB_SRC_MATRIX;
      routed <= 1'b0;
      tick(3);
      `CHK(count_out, 8'h04, "unrouted")
      src_sel <= CDB_SRC_OFF;
      routed <= 1'b1;
      tick(3);
      `CHK(count_out, 8'h04, "off")
      src_sel <= CDB_SRC_MATRIX;
      tick(1);
      `CHK(count_out, 8'h03, "matrix")
      src_sel <= CDB_SRC_OSC;
      cnt_rst <= 1'b1;
      tick(3);
      `CHK(count_out, 8'h05, "reset reload")
      cnt_rst <= 1'b0;
      tick(2);
   endtask : t_src
   // 10 ns pulses every 60 ns are blocked, a steady level passes
   task automatic t_flt();
      fork
         tick(12);
         repeat (8) begin
            flt_in <= 1'b1;
            repeat (2) @(posedge clk);
            flt_in <= 1'b0;
            repeat (10) @(posedge clk);
         end
      join
      `CHK(delay_out, 1'b0, "glitch passed")
      flt_in <= 1'b1;
      tick(7);
      `CHK(delay_out, 1'b1, "level blocked")
   endtask : t_flt
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK(count_out, CDB_CNT_RST, "count rst")
      `CHK(snap_out, CDB_SNAP_RST, "snap rst")
      t_count();
      t_read();
      t_src();
      t_flt();
      results();
   end
   // Hang guard
   initial begin
      #50us;
      error_cnt++;
      results();
   end
endmodule : test_counter_delay_with_readback
